// ---- verilog/wss_pkg.sv ----
// Constants, register map and mode codes of the steering/shutdown block
package wss_pkg;

	localparam int ADDR_W = 5;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	localparam int NUM_CH = 4;
	localparam int NUM_SRC = 7;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 5'h00;
	localparam logic [ADDR_W-1:0] OFF_POL = 5'h04;
	localparam logic [ADDR_W-1:0] OFF_SDEN = 5'h08;
	localparam logic [ADDR_W-1:0] OFF_STEER = 5'h0C;
	localparam logic [ADDR_W-1:0] OFF_CLKSEL = 5'h10;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h14;
	localparam logic [ADDR_W-1:0] OFF_SDLVL = 5'h18;

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int CTRL_EN_BIT = 7;
	localparam int MODE_LSB = 0;
	localparam int MODE_W = 3;
	localparam int SDEN_FIXED_BIT = 7;
	localparam int STR_EN_LSB = 0;
	localparam int STR_OVR_LSB = 4;
	localparam int CLK_CS_BIT = 0;
	localparam int STAT_SD_BIT = 7;
	localparam int STAT_IN_BIT = 5;
	localparam int POL_LSB = 0;
	localparam int SDLVL_LSB = 0;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
	localparam logic [NUM_CH-1:0] POL_RST = 4'h0;
	localparam logic [NUM_SRC-1:0] SDEN_RST = 7'h00;
	localparam logic [REG_W-1:0] STEER_RST = 8'h00;
	localparam logic [NUM_CH-1:0] SDLVL_RST = 4'h0;

	localparam int FAST_OSC_MHZ = 16;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		MODE_STEER = 3'b000,
		MODE_SYNC_STEER = 3'b001,
		MODE_FWD_BRIDGE = 3'b010,
		MODE_REV_BRIDGE = 3'b011,
		MODE_HALF_BRIDGE = 3'b100,
		MODE_PUSH_PULL = 3'b101,
		MODE_RSV_6 = 3'b110,
		MODE_RSV_7 = 3'b111
	} wss_mode_e;

endpackage

// ---- verilog/wss_chan.sv ----
// One output channel: polarity, steering override and shutdown level
`timescale 1ns/1ps
module wss_chan (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_enable,
	input wire logic i_data,
	input wire logic i_invert,
	input wire logic i_steer_mode,
	input wire logic i_steer_en,
	input wire logic i_override,
	input wire logic i_shutdown,
	input wire logic i_sd_level,
	output logic o_out
);

	logic out_r;
	logic out_nxt;

	always_comb begin
		if (!i_enable) begin
			out_nxt = 1'b0;
		end else if (i_shutdown) begin
			out_nxt = i_sd_level;
		end else if (i_steer_mode && !i_steer_en) begin
			out_nxt = i_override;
		end else begin
			out_nxt = i_data ^ i_invert;
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			out_r <= 1'b0;
		end else begin
			out_r <= out_nxt;
		end
	end

	assign o_out = out_r;

endmodule

// ---- verilog/wss_top.sv ----
// Shutdown source select, output steering and clock select with AXI4-Lite
//
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module wss_top #(
	parameter int ADDR_W = wss_pkg::ADDR_W
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RSTN,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	// AXI4-Lite write data
	input wire logic [wss_pkg::DATA_W-1:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	// AXI4-Lite write response
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	// AXI4-Lite read data
	output logic [wss_pkg::DATA_W-1:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	// Waveform and shutdown sources
	input wire logic I_DATA_WAVE,
	input wire logic I_LOGIC_CELL2_OUT,
	input wire logic I_CMP2_OUT,
	input wire logic I_CMP1_OUT,
	input wire logic I_TIMER_SIX_POST,
	input wire logic I_TIMER_POST_B,
	input wire logic I_TIMER_TWO_POST,
	input wire logic I_SD_PIN,
	// Outputs to the switch drivers, shutdown flag and clock mux select
	output logic O_OUT_A,
	output logic O_OUT_B,
	output logic O_OUT_C,
	output logic O_OUT_D,
	output logic O_SHUTDOWN,
	output logic O_CLK_SEL_FAST
);

	localparam int RW = wss_pkg::REG_W;
	localparam int NC = wss_pkg::NUM_CH;
	localparam int NS = wss_pkg::NUM_SRC;
	localparam int DW = wss_pkg::DATA_W;

	////////////////////////////////////////////////////////////////////////
	// Registers

	logic [RW-1:0] ctrl_r;
	logic [NC-1:0] pol_r;
	logic [NS-1:0] sden_r;
	logic [RW-1:0] steer_r;
	logic clk_sel_r;
	logic [NC-1:0] sd_lvl_r;
	logic sd_r;
	logic sd_nxt;
	logic sd_hold_r;
	logic [NC-1:0] steer_act_r;
	logic data_d_r;

	////////////////////////////////////////////////////////////////////////
	// Bus state

	logic aw_hold_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic w_hold_r;
	logic [DW-1:0] w_data_r;
	logic w_lane0_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [1:0] rresp_r;
	logic [DW-1:0] rdata_r;

	logic wr_go;
	logic wr_hit;
	logic wr_en;
	logic rd_go;
	logic rd_hit;
	logic [RW-1:0] rd_byte;
	logic [RW-1:0] wr_byte;

	////////////////////////////////////////////////////////////////////////
	// Write channel

	assign O_AWREADY = !aw_hold_r && !bvalid_r;
	assign O_WREADY = !w_hold_r && !bvalid_r;
	assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
	assign wr_byte = w_data_r[RW-1:0];

	always_comb begin
		unique case (aw_addr_r)
			wss_pkg::OFF_CTRL,
			wss_pkg::OFF_POL,
			wss_pkg::OFF_SDEN,
			wss_pkg::OFF_STEER,
			wss_pkg::OFF_CLKSEL,
			wss_pkg::OFF_STATUS,
			wss_pkg::OFF_SDLVL: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// Only byte lane 0 carries register bits
	assign wr_en = wr_go && wr_hit && w_lane0_r;

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			aw_hold_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (I_AWVALID && O_AWREADY) begin
			aw_hold_r <= 1'b1;
			aw_addr_r <= I_AWADDR;
		end else if (wr_go) begin
			aw_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			w_hold_r <= 1'b0;
			w_data_r <= '0;
			w_lane0_r <= 1'b0;
		end else if (I_WVALID && O_WREADY) begin
			w_hold_r <= 1'b1;
			w_data_r <= I_WDATA;
			w_lane0_r <= I_WSTRB[0];
		end else if (wr_go) begin
			w_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			bvalid_r <= 1'b0;
			bresp_r <= wss_pkg::RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_hit ? wss_pkg::RESP_OKAY : wss_pkg::RESP_SLVERR;
		end else if (I_BREADY) begin
			bvalid_r <= 1'b0;
		end
	end

	assign O_BVALID = bvalid_r;
	assign O_BRESP = bresp_r;

	////////////////////////////////////////////////////////////////////////
	// Software registers

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			ctrl_r <= wss_pkg::CTRL_RST;
		end else if (wr_en && aw_addr_r == wss_pkg::OFF_CTRL) begin
			ctrl_r <= wr_byte;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			pol_r <= wss_pkg::POL_RST;
		end else if (wr_en && aw_addr_r == wss_pkg::OFF_POL) begin
			pol_r <= wr_byte[wss_pkg::POL_LSB +: NC];
		end
	end

	// Top bit is not stored; the read path forces it high
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			sden_r <= wss_pkg::SDEN_RST;
		end else if (wr_en && aw_addr_r == wss_pkg::OFF_SDEN) begin
			sden_r <= wr_byte[NS-1:0];
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			steer_r <= wss_pkg::STEER_RST;
		end else if (wr_en && aw_addr_r == wss_pkg::OFF_STEER) begin
			steer_r <= wr_byte;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			clk_sel_r <= 1'b0;
		end else if (wr_en && aw_addr_r == wss_pkg::OFF_CLKSEL) begin
			clk_sel_r <= wr_byte[wss_pkg::CLK_CS_BIT];
		end
	end

	// Drives the external clock mux: 1 picks the fast oscillator
	assign O_CLK_SEL_FAST = clk_sel_r;

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			sd_lvl_r <= wss_pkg::SDLVL_RST;
		end else if (wr_en && aw_addr_r == wss_pkg::OFF_SDLVL) begin
			sd_lvl_r <= wr_byte[wss_pkg::SDLVL_LSB +: NC];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Shutdown sources

	logic [NS-1:0] src_vec;
	logic trip;

	// Bit order matches the enable register, highest bit first
	assign src_vec = {
		I_LOGIC_CELL2_OUT,
		I_CMP2_OUT,
		I_CMP1_OUT,
		I_TIMER_SIX_POST,
		I_TIMER_POST_B,
		I_TIMER_TWO_POST,
		I_SD_PIN
	};

	assign trip = |(src_vec & sden_r);

	// A trip in the same cycle as a software clear keeps the bit set
	always_comb begin
		sd_nxt = sd_r;
		if (wr_en && aw_addr_r == wss_pkg::OFF_STATUS) begin
			sd_nxt = wr_byte[wss_pkg::STAT_SD_BIT];
		end
		if (trip) begin
			sd_nxt = 1'b1;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			sd_r <= 1'b0;
		end else begin
			sd_r <= sd_nxt;
		end
	end

	assign O_SHUTDOWN = sd_r;

	////////////////////////////////////////////////////////////////////////
	// Waveform edge, shutdown hold and steering buffer

	logic data_rise;
	logic steer_mode;
	logic [NC-1:0] steer_wr;

	assign data_rise = I_DATA_WAVE && !data_d_r;
	assign steer_wr = steer_r[wss_pkg::STR_EN_LSB +: NC];

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			data_d_r <= 1'b0;
		end else begin
			data_d_r <= I_DATA_WAVE;
		end
	end

	// Outputs stay shut down until a rising waveform edge after the clear
	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			sd_hold_r <= 1'b0;
		end else if (sd_nxt) begin
			sd_hold_r <= 1'b1;
		end else if (data_rise) begin
			sd_hold_r <= 1'b0;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			steer_act_r <= '0;
		end else begin
			unique case (wss_pkg::wss_mode_e'(ctrl_r[wss_pkg::MODE_LSB +:
				wss_pkg::MODE_W]))
				wss_pkg::MODE_STEER: begin
					steer_act_r <= steer_wr;
				end
				wss_pkg::MODE_SYNC_STEER: begin
					if (data_rise) begin
						steer_act_r <= steer_wr;
					end
				end
				default: begin
					steer_act_r <= steer_act_r;
				end
			endcase
		end
	end

	// Steering applies only in modes 000 and 001
	assign steer_mode = ctrl_r[wss_pkg::MODE_LSB + 1 +: 2] == 2'h0;

	////////////////////////////////////////////////////////////////////////
	// Output channels

	logic [NC-1:0] out_vec;

	for (genvar ch = 0; ch < NC; ch++) begin : g_ch
		wss_chan u_chan (
			.i_clk(I_SYS_CLK),
			.i_rstn(I_RSTN),
			.i_enable(ctrl_r[wss_pkg::CTRL_EN_BIT]),
			.i_data(I_DATA_WAVE),
			.i_invert(pol_r[ch]),
			.i_steer_mode(steer_mode),
			.i_steer_en(steer_act_r[ch]),
			.i_override(steer_r[wss_pkg::STR_OVR_LSB + ch]),
			.i_shutdown(sd_hold_r),
			.i_sd_level(sd_lvl_r[ch]),
			.o_out(out_vec[ch])
		);
	end

	assign O_OUT_A = out_vec[0];
	assign O_OUT_B = out_vec[1];
	assign O_OUT_C = out_vec[2];
	assign O_OUT_D = out_vec[3];

	////////////////////////////////////////////////////////////////////////
	// Read channel

	assign O_ARREADY = !rvalid_r;
	assign rd_go = I_ARVALID && O_ARREADY;

	always_comb begin
		rd_byte = '0;
		rd_hit = 1'b1;
		unique case (I_ARADDR)
			wss_pkg::OFF_CTRL: rd_byte = ctrl_r;
			wss_pkg::OFF_POL: rd_byte[wss_pkg::POL_LSB +: NC] = pol_r;
			wss_pkg::OFF_SDEN: begin
				rd_byte[NS-1:0] = sden_r;
				rd_byte[wss_pkg::SDEN_FIXED_BIT] = 1'b1;
			end
			wss_pkg::OFF_STEER: rd_byte = steer_r;
			wss_pkg::OFF_CLKSEL: rd_byte[wss_pkg::CLK_CS_BIT] = clk_sel_r;
			wss_pkg::OFF_STATUS: begin
				rd_byte[wss_pkg::STAT_SD_BIT] = sd_r;
				rd_byte[wss_pkg::STAT_IN_BIT] = I_DATA_WAVE;
			end
			wss_pkg::OFF_SDLVL: rd_byte[wss_pkg::SDLVL_LSB +: NC] = sd_lvl_r;
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
		if (!I_RSTN) begin
			rvalid_r <= 1'b0;
			rresp_r <= wss_pkg::RESP_OKAY;
			rdata_r <= '0;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rresp_r <= rd_hit ? wss_pkg::RESP_OKAY : wss_pkg::RESP_SLVERR;
			rdata_r <= {{(DW - RW){1'b0}}, rd_byte};
		end else if (I_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	assign O_RVALID = rvalid_r;
	assign O_RRESP = rresp_r;
	assign O_RDATA = rdata_r;

endmodule

// ---- verification/wss_top_props.sv ----
// Bus handshake and register side-effect checks of wss_top
`timescale 1ns/1ps
module wss_top_props #(
	parameter int ADDR_W = wss_pkg::ADDR_W
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RSTN,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [ADDR_W-1:0] I_ARADDR,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [wss_pkg::DATA_W-1:0] O_RDATA,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic O_CLK_SEL_FAST
);
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RSTN);

	// Response two edges after both write halves are taken together
	property p_b_lat;
		I_AWVALID && O_AWREADY && I_WVALID && O_WREADY
			|-> ##2 O_BVALID;
	endproperty
	a_b_lat: assert property (p_b_lat)
		else $error("write response late");

	property p_r_lat;
		I_ARVALID && O_ARREADY |=> O_RVALID;
	endproperty
	a_r_lat: assert property (p_r_lat)
		else $error("read data late");

	property p_b_drop;
		O_BVALID && I_BREADY |=> !O_BVALID;
	endproperty
	a_b_drop: assert property (p_b_drop)
		else $error("write response stuck");

	property p_r_drop;
		O_RVALID && I_RREADY |=> !O_RVALID;
	endproperty
	a_r_drop: assert property (p_r_drop)
		else $error("read data stuck");

	property p_w_busy;
		O_BVALID |-> !O_AWREADY && !O_WREADY;
	endproperty
	a_w_busy: assert property (p_w_busy)
		else $error("write taken while busy");

	property p_r_up;
		O_RVALID |-> O_RDATA[31:8] == 24'h000000;
	endproperty
	a_r_up: assert property (p_r_up)
		else $error("read upper bits set");

	property p_sden7;
		I_ARVALID && O_ARREADY && I_ARADDR == wss_pkg::OFF_SDEN
			|=> O_RDATA[7];
	endproperty
	a_sden7: assert property (p_sden7)
		else $error("enable bit 7 low");

	// Clock select moves only with a completed write
	property p_clk;
		$changed(O_CLK_SEL_FAST) |-> $rose(O_BVALID);
	endproperty
	a_clk: assert property (p_clk)
		else $error("clock select moved");

	cover property (O_BVALID && I_BREADY);
	cover property ($rose(O_CLK_SEL_FAST));
	cover property (O_RVALID && O_RDATA[7]);
endmodule
bind wss_top wss_top_props #(.ADDR_W(ADDR_W)) u_props (.*);

// ---- verification/wss_far.sv ----
// Far side: shutdown sources, data waveform and driver input sampling
`timescale 1ns/1ps
module wss_far (
	input wire logic i_clk,
	input wire logic [6:0] i_trip,
	input wire logic i_wave,
	input wire logic [3:0] i_drv,
	output logic [6:0] o_src,
	output logic o_wave,
	output logic [3:0] o_seen
);
	initial begin
		o_src = 7'h00;
		o_wave = 1'h0;
		o_seen = 4'h0;
	end
	// Sources move just after an edge, like on-chip logic
	always @(posedge i_clk) begin
		o_src <= i_trip;
		o_wave <= i_wave;
		o_seen <= i_drv;
	end
endmodule

// ---- verification/wss_top_tb.sv ----
// Self-checking bench of wss_top
`timescale 1ns/1ps
module wss_top_tb;
	logic clk = 1'h0, rstn = 1'h0, awv = 1'h0, wv = 1'h0, bready = 1'h0;
	logic arv = 1'h0, rready = 1'h0, wave_cmd = 1'h0;
	logic [4:0] awaddr = 5'h00, araddr = 5'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic [6:0] trip = 7'h00;
	logic awr, wr_rdy, bv, arr, rv, sd, fast, wave;
	logic [31:0] rdata;
	logic [3:0] outs, seen;
	logic [1:0] bresp, rresp;
	logic [6:0] src;
	int fail_count = 0, cmp_count = 0, cyc = 0;
	wss_top u_dut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_AWADDR(awaddr),
		.I_AWVALID(awv), .O_AWREADY(awr), .I_WDATA(wdata), .I_WSTRB(wstrb),
		.I_WVALID(wv), .O_WREADY(wr_rdy), .O_BRESP(bresp), .O_BVALID(bv),
		.I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arv),
		.O_ARREADY(arr), .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rv),
		.I_RREADY(rready), .I_DATA_WAVE(wave), .I_LOGIC_CELL2_OUT(src[6]),
		.I_CMP2_OUT(src[5]), .I_CMP1_OUT(src[4]), .I_TIMER_SIX_POST(src[3]),
		.I_TIMER_POST_B(src[2]), .I_TIMER_TWO_POST(src[1]),
		.I_SD_PIN(src[0]), .O_OUT_A(outs[0]), .O_OUT_B(outs[1]),
		.O_OUT_C(outs[2]), .O_OUT_D(outs[3]), .O_SHUTDOWN(sd),
		.O_CLK_SEL_FAST(fast));
	wss_far u_far (.i_clk(clk), .i_trip(trip), .i_wave(wave_cmd),
		.i_drv(outs), .o_src(src), .o_wave(wave), .o_seen(seen));
	initial begin
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (fail_count == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic pa, pw, ta, tw;
		@(posedge clk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		wstrb <= s;
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		pa = 1'h1;
		pw = 1'h1;
		do begin
			@(negedge clk);
			ta = pa && awr;
			tw = pw && wr_rdy;
			@(posedge clk);
			if (ta) begin
				awv <= 1'h0;
				pa = 1'h0;
			end
			if (tw) begin
				wv <= 1'h0;
				pw = 1'h0;
			end
		end while (pa || pw);
		do @(negedge clk); while (bv !== 1'h1);
		chk({30'h0, bresp}, {30'h0, er});
		@(posedge clk);
		bready <= 1'h0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] ed,
		input logic [1:0] er);
		@(posedge clk);
		araddr <= a;
		arv <= 1'h1;
		rready <= 1'h1;
		do @(negedge clk); while (arr !== 1'h1);
		@(posedge clk);
		arv <= 1'h0;
		do @(negedge clk); while (rv !== 1'h1);
		chk(rdata, {24'h000000, ed});
		chk({30'h0, rresp}, {30'h0, er});
		@(posedge clk);
		rready <= 1'h0;
	endtask
	// Outputs as the switch drivers see them, after the pipeline settles
	task automatic look(input logic [3:0] e);
		repeat (5) @(negedge clk);
		chk({28'h0, seen}, {28'h0, e});
	endtask
	task automatic set_wave(input logic b);
		@(posedge clk);
		wave_cmd <= b;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd(wss_pkg::OFF_SDEN, 8'h80, wss_pkg::RESP_OKAY);
		rd(wss_pkg::OFF_STEER, 8'h00, wss_pkg::RESP_OKAY);
		rd(wss_pkg::OFF_CLKSEL, 8'h00, wss_pkg::RESP_OKAY);
		look(4'h0);
	endtask
	task automatic t_steer();
		wr(wss_pkg::OFF_CTRL, 8'h80, 4'h1, wss_pkg::RESP_OKAY);
		wr(wss_pkg::OFF_POL, 8'h01, 4'h1, wss_pkg::RESP_OKAY);
		wr(wss_pkg::OFF_STEER, 8'h25, 4'h1, wss_pkg::RESP_OKAY);
		set_wave(1'h1);
		look(4'h6);
		set_wave(1'h0);
		look(4'h3);
	endtask
	task automatic t_modes();
		for (int i = 2; i < 8; i++) begin
			wr(wss_pkg::OFF_CTRL, 8'h80 | 8'(i), 4'h1, wss_pkg::RESP_OKAY);
			look(4'h1);
		end
		wr(wss_pkg::OFF_CTRL, 8'h80, 4'h0, wss_pkg::RESP_OKAY);
		look(4'h1);
		wr(5'h1C, 8'h80, 4'h1, wss_pkg::RESP_SLVERR);
		rd(5'h1C, 8'h00, wss_pkg::RESP_SLVERR);
	endtask
	task automatic t_sync();
		wr(wss_pkg::OFF_CTRL, 8'h81, 4'h1, wss_pkg::RESP_OKAY);
		wr(wss_pkg::OFF_STEER, 8'h2F, 4'h1, wss_pkg::RESP_OKAY);
		look(4'h3);
		set_wave(1'h1);
		look(4'hE);
	endtask
	task automatic t_sd();
		logic [6:0] b;
		wr(wss_pkg::OFF_SDLVL, 8'h0A, 4'h1, wss_pkg::RESP_OKAY);
		for (int i = 0; i < 7; i++) begin
			b = 7'h01 << i;
			wr(wss_pkg::OFF_SDEN, {1'h0, b}, 4'h1, wss_pkg::RESP_OKAY);
			@(posedge clk);
			trip <= ~b;
			look(4'hE);
			chk({31'h0, sd}, 32'h0);
			@(posedge clk);
			trip <= 7'h7F;
			look(4'hA);
			rd(wss_pkg::OFF_STATUS, 8'hA0, wss_pkg::RESP_OKAY);
			chk({31'h0, sd}, 32'h1);
			// A clear while the source still trips must lose
			wr(wss_pkg::OFF_STATUS, 8'h00, 4'h1, wss_pkg::RESP_OKAY);
			chk({31'h0, sd}, 32'h1);
			@(posedge clk);
			trip <= 7'h00;
			wr(wss_pkg::OFF_STATUS, 8'h00, 4'h1, wss_pkg::RESP_OKAY);
			chk({31'h0, sd}, 32'h0);
			look(4'hA);
			set_wave(1'h0);
			look(4'hA);
			set_wave(1'h1);
			look(4'hE);
		end
	endtask
	task automatic t_clk();
		wr(wss_pkg::OFF_CLKSEL, 8'h01, 4'h1, wss_pkg::RESP_OKAY);
		chk({31'h0, fast}, 32'h1);
		rd(wss_pkg::OFF_CLKSEL, 8'h01, wss_pkg::RESP_OKAY);
		wr(wss_pkg::OFF_CLKSEL, 8'h00, 4'h1, wss_pkg::RESP_OKAY);
		chk({31'h0, fast}, 32'h0);
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'h1;
		t_reset();
		t_steer();
		t_modes();
		t_sync();
		t_sd();
		t_clk();
		finish_test();
	end
endmodule
